// *** ispr_pkg.sv ***
// package for the interrupt source priority register block
// assumes a single 25 MHz hclk domain and an ahb-lite register bus
////////////////////////////////////////////////////////////////////////////////
package ispr_pkg;
  // register byte offsets
  localparam logic [15:0] ADDR_PRIO1 = 16'hF614;
  localparam logic [15:0] ADDR_PRIO2 = 16'hF618;
  localparam logic [15:0] ADDR_IRQ_STATUS = 16'hF640;
  localparam logic [15:0] ADDR_IRQ_MASK = 16'hF644;
  localparam logic [15:0] ADDR_SRC_STATE = 16'hF648;
  // field positions (low bit of each 3-bit field)
  localparam int LVL_W = 3;
  localparam int POS_HI = 24;
  localparam int POS_MID = 16;
  localparam int POS_LOW8 = 8;
  localparam int POS_LOW0 = 0;
  // reset values
  localparam logic [2:0] LVL_RST = 3'h0;
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  // number of sources served by this block
  localparam int NSRC = 7;
  // forward-path index of each source
  localparam int S_SRC19 = 0;
  localparam int S_SRC18 = 1;
  localparam int S_SRC3 = 2;
  localparam int S_SRC2 = 3;
  localparam int S_SRC21 = 4;
  localparam int S_SRC5 = 5;
  localparam int S_SRC4 = 6;
  // bus slave states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_DATA = 2'b10
  } ispr_bus_state_t;
  // extract a priority field at a position from a register word
  function automatic logic [2:0] ispr_field(input logic [31:0] w,
                                            input int pos);
    ispr_field = w[pos +: 3];
  endfunction
endpackage

// *** ispr_lvl_if.sv ***
// interface carrying the programmed level of each source to the gate
// assumes both modports live in the hclk domain
interface ispr_lvl_if;
  logic [20:0] level;
  logic [6:0] raw_req;
  logic [6:0] fwd_req;
  logic [20:0] fwd_level;
  modport regs (output level, output raw_req, input fwd_req,
                input fwd_level);
  modport gate (input level, input raw_req, output fwd_req,
                output fwd_level);
endinterface

// *** ispr_gate.sv ***
// gate that forwards only sources whose programmed level is nonzero
// assumes raw requests are synchronous to hclk
module ispr_gate (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // level and request carrier
  ispr_lvl_if.gate lv
);
  logic [6:0] nxt_req;
  logic [20:0] nxt_lvl;
  logic [6:0] req_ff;
  logic [20:0] lvl_ff;

  // mask each request by whether its level is nonzero
  always_comb begin
    nxt_req = '0;
    nxt_lvl = '0;
    for (int i = 0; i < ispr_pkg::NSRC; i++) begin
      if (lv.level[3*i +: 3] != ispr_pkg::LVL_RST) begin
        nxt_req[i] = lv.raw_req[i];
        nxt_lvl[3*i +: 3] = lv.level[3*i +: 3];
      end
    end
  end

  // register forwarded requests and levels
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_ff <= 7'h00;
      lvl_ff <= 21'h000000;
    end else begin
      req_ff <= nxt_req;
      lvl_ff <= nxt_lvl;
    end
  end

  assign lv.fwd_req = req_ff;
  assign lv.fwd_level = lvl_ff;
endmodule

// *** ispr_top.sv ***
// interrupt source priority registers with ahb-lite slave and gating
// assumes one ahb-lite master, single word transfers, hclk at 25 MHz
//
// Chosen here: the AHB-Lite register port.
module ispr_top (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // raw source requests, index order 19,18,3,2,21,5,4
  input wire logic [6:0] src_req,
  // forwarded requests and levels toward priority resolution
  output logic [6:0] fwd_req,
  output logic [20:0] fwd_level,
  // interrupt
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  // declarations
  ispr_lvl_if lv ();
  ispr_pkg::ispr_bus_state_t state_ff;
  logic [15:0] addr_ff;
  logic wr_ff;
  logic [31:0] prio1_ff;
  logic [31:0] prio2_ff;
  logic [6:0] status_ff;
  logic [6:0] mask_ff;
  logic [6:0] prev_fwd_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic take;
  logic wr_prio1;
  logic wr_prio2;
  logic wr_status;
  logic wr_mask;
  logic [6:0] rise;
  logic [31:0] m1;
  logic [31:0] m2;

  // writable bits of each priority register
  assign m1 = {5'h00, 3'h7, 5'h00, 3'h7, 5'h00, 3'h7, 5'h00, 3'h7};
  assign m2 = {5'h00, 3'h7, 13'h0000, 3'h7, 5'h00, 3'h7};

  ////////////////////////////////////////////////////////////////////////////
  // address phase capture
  assign take = hsel && hready && htrans[1];

  // bus state and captured address
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= ispr_pkg::ST_IDLE;
      addr_ff <= 16'h0000;
      wr_ff <= 1'b0;
    end else begin
      case (state_ff)
        ispr_pkg::ST_IDLE: begin
          if (take) begin
            state_ff <= ispr_pkg::ST_DATA;
          end
        end
        ispr_pkg::ST_DATA: begin
          if (!take) begin
            state_ff <= ispr_pkg::ST_IDLE;
          end
        end
        default: begin
          state_ff <= ispr_pkg::ST_IDLE;
        end
      endcase
      if (take) begin
        addr_ff <= haddr[15:0];
        wr_ff <= hwrite;
      end else begin
        wr_ff <= 1'b0;
      end
    end
  end

  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // write strobes in the data phase
  always_comb begin
    wr_prio1 = 1'b0;
    wr_prio2 = 1'b0;
    wr_status = 1'b0;
    wr_mask = 1'b0;
    if (state_ff == ispr_pkg::ST_DATA && wr_ff) begin
      wr_prio1 = (addr_ff == ispr_pkg::ADDR_PRIO1);
      wr_prio2 = (addr_ff == ispr_pkg::ADDR_PRIO2);
      wr_status = (addr_ff == ispr_pkg::ADDR_IRQ_STATUS);
      wr_mask = (addr_ff == ispr_pkg::ADDR_IRQ_MASK);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // priority register 1: fields for sources 19, 18, 3, 2
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prio1_ff <= ispr_pkg::REG_RST;
    end else if (wr_prio1) begin
      prio1_ff <= hwdata & m1;
    end
  end

  // priority register 2: fields for sources 21, 5, 4
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prio2_ff <= ispr_pkg::REG_RST;
    end else if (wr_prio2) begin
      prio2_ff <= hwdata & m2;
    end
  end

  // hand each source's level to the gate
  assign lv.level[3*ispr_pkg::S_SRC19 +: 3] =
    ispr_pkg::ispr_field(prio1_ff, ispr_pkg::POS_HI);
  assign lv.level[3*ispr_pkg::S_SRC18 +: 3] =
    ispr_pkg::ispr_field(prio1_ff, ispr_pkg::POS_MID);
  assign lv.level[3*ispr_pkg::S_SRC3 +: 3] =
    ispr_pkg::ispr_field(prio1_ff, ispr_pkg::POS_LOW8);
  assign lv.level[3*ispr_pkg::S_SRC2 +: 3] =
    ispr_pkg::ispr_field(prio1_ff, ispr_pkg::POS_LOW0);
  assign lv.level[3*ispr_pkg::S_SRC21 +: 3] =
    ispr_pkg::ispr_field(prio2_ff, ispr_pkg::POS_HI);
  assign lv.level[3*ispr_pkg::S_SRC5 +: 3] =
    ispr_pkg::ispr_field(prio2_ff, ispr_pkg::POS_LOW8);
  assign lv.level[3*ispr_pkg::S_SRC4 +: 3] =
    ispr_pkg::ispr_field(prio2_ff, ispr_pkg::POS_LOW0);
  assign lv.raw_req = src_req;

  // gating of disabled sources
  ispr_gate u_gate (
    .hclk(hclk),
    .hresetn(hresetn),
    .lv(lv)
  );

  assign fwd_req = lv.fwd_req;
  assign fwd_level = lv.fwd_level;

  ////////////////////////////////////////////////////////////////////////////
  // rising edges of forwarded requests are the status events
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_fwd_ff <= 7'h00;
    end else begin
      prev_fwd_ff <= lv.fwd_req;
    end
  end
  assign rise = lv.fwd_req & ~prev_fwd_ff;

  // sticky status, write one to clear, a new event wins over the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_ff <= 7'h00;
    end else begin
      status_ff <= (status_ff & ~(wr_status ? hwdata[6:0] : 7'h00)) | rise;
    end
  end

  // interrupt mask, one enables a status bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_ff <= 7'h00;
    end else if (wr_mask) begin
      mask_ff <= hwdata[6:0];
    end
  end

  assign irq = |(status_ff & mask_ff);

  ////////////////////////////////////////////////////////////////////////////
  // read data for the next data phase
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (take && !hwrite) begin
      case (haddr[15:0])
        ispr_pkg::ADDR_PRIO1: nxt_rdata = prio1_ff;
        ispr_pkg::ADDR_PRIO2: nxt_rdata = prio2_ff;
        ispr_pkg::ADDR_IRQ_STATUS: nxt_rdata = {25'h0000000, status_ff};
        ispr_pkg::ADDR_IRQ_MASK: nxt_rdata = {25'h0000000, mask_ff};
        ispr_pkg::ADDR_SRC_STATE: nxt_rdata = {25'h0000000, lv.fwd_req};
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  // read data register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign hrdata = rdata_ff;
endmodule

// *** ispr_properties.sv ***
// port assertions for the priority register block
// assumes one hclk domain and hreadyout looped back as hready
module ispr_chk (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // sources and forward path
  input wire logic [6:0] src_req,
  input wire logic [6:0] fwd_req,
  input wire logic [20:0] fwd_level,
  input wire logic irq
);
  logic tk;
  logic a1_ff, a2_ff, v1_ff, v2_ff, rd_ff;
  logic [31:0] rm_ff;
  logic [11:0] w1_ff;
  logic [8:0] w2_ff;
  logic [6:0] nz;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////
  // taken transfer, data phase tracking and captured field writes
  assign tk = hsel & hready & htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a1_ff <= 1'b0;
      a2_ff <= 1'b0;
      v1_ff <= 1'b0;
      v2_ff <= 1'b0;
      rd_ff <= 1'b0;
      rm_ff <= 32'h0;
      w1_ff <= 12'h0;
      w2_ff <= 9'h0;
    end else begin
      a1_ff <= tk & hwrite & (haddr[15:0] == ispr_pkg::ADDR_PRIO1);
      a2_ff <= tk & hwrite & (haddr[15:0] == ispr_pkg::ADDR_PRIO2);
      v1_ff <= a1_ff;
      v2_ff <= a2_ff;
      rd_ff <= tk & !hwrite;
      rm_ff <= (haddr[15:0] == ispr_pkg::ADDR_PRIO1) ? 32'h0707_0707 :
               (haddr[15:0] == ispr_pkg::ADDR_PRIO2) ? 32'h0700_0707 :
               (haddr[15:4] == 12'hF64) ? 32'h0000_007F : 32'h0;
      if (a1_ff)
        w1_ff <= {hwdata[2:0], hwdata[10:8], hwdata[18:16], hwdata[26:24]};
      if (a2_ff)
        w2_ff <= {hwdata[2:0], hwdata[10:8], hwdata[26:24]};
    end
  end
  // nonzero flag of each forwarded level
  always_comb begin
    for (int i = 0; i < 7; i++) nz[i] = |fwd_level[3*i +: 3];
  end
  ////////////////////////////////////////////////////////////////////////
  chk_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  chk_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  chk_rst_clear: assert property ($rose(hresetn) |->
    fwd_level == 21'h0 && fwd_req == 7'h0 && !irq)
    else $error("outputs not clear after reset");
  chk_idle_rdata: assert property (!rd_ff |-> hrdata == 32'h0)
    else $error("hrdata outside read data phase");
  chk_rsvd_zero: assert property (rd_ff |-> (hrdata & ~rm_ff) == 32'h0)
    else $error("reserved bits read nonzero");
  chk_fwd_gate: assert property (
    ##1 fwd_req == ($past(src_req) & nz))
    else $error("forwarded request not gated by level");
  chk_reg1_map: assert property (v1_ff |-> ##[0:1]
    fwd_level[11:0] == w1_ff)
    else $error("register 1 fields misplaced");
  chk_reg2_map: assert property (v2_ff |-> ##[0:1]
    fwd_level[20:12] == w2_ff)
    else $error("register 2 fields misplaced");
  cover property (v1_ff);
  cover property (rd_ff);
  cover property ($rose(irq));
endmodule
bind ispr_top ispr_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .src_req(src_req), .fwd_req(fwd_req), .fwd_level(fwd_level), .irq(irq));

// *** ispr_core_model.sv ***
// model of the core side: drives sources, resolves forwarded levels
// assumes the bench sets src_pat just after a rising edge
module ispr_core_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // sources
  input wire logic [6:0] src_pat,
  output logic [6:0] src_req,
  // forward path
  input wire logic [6:0] fwd_req,
  input wire logic [20:0] fwd_level,
  output logic [2:0] best_lvl
);
  // sources follow the bench pattern one edge later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) src_req <= 7'h00;
    else src_req <= src_pat;
  end
  // highest forwarded level wins, zero means nothing pending
  always_comb begin
    best_lvl = 3'h0;
    for (int i = 0; i < 7; i++) begin
      if (fwd_req[i] && fwd_level[3*i +: 3] > best_lvl)
        best_lvl = fwd_level[3*i +: 3];
    end
  end
endmodule

// *** ispr_tb_top.sv ***
// bench for the priority register block over ahb-lite
// assumes hreadyout drives hready and the core model on the far side
module ispr_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] P1 = ispr_pkg::ADDR_PRIO1;
  localparam logic [15:0] P2 = ispr_pkg::ADDR_PRIO2;
  localparam logic [15:0] ST = ispr_pkg::ADDR_IRQ_STATUS;
  localparam logic [15:0] MK = ispr_pkg::ADDR_IRQ_MASK;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, best_lvl, lv;
  logic [6:0] src_pat, src_req, fwd_req;
  logic [20:0] fwd_level;
  int n_mismatch, cmp_count;
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  ispr_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .src_req(src_req),
    .fwd_req(fwd_req), .fwd_level(fwd_level), .irq(irq));
  ispr_core_model u_core (.hclk(hclk), .hresetn(hresetn),
    .src_pat(src_pat), .src_req(src_req), .fwd_req(fwd_req),
    .fwd_level(fwd_level), .best_lvl(best_lvl));
  ////////////////////////////////////////////////////////////////////////
  // verdict, comparison and bus tasks
  task print_verdict;
    if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wrdy;
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 50) begin
        n_mismatch++;
        print_verdict;
      end
      @(posedge hclk);
    end
  endtask
  task xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {16'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    wrdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wrdy;
    rd = hrdata;
  endtask
  task rchk(input string nm, input logic [15:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {hresetn, hsel, hwrite, htrans, hsize, src_pat} = '0;
    {haddr, hwdata, n_mismatch, cmp_count} = '0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk("prio1", P1, 32'h0);
    rchk("prio2", P2, 32'h0);
    chk("fwd_level", 32'h0, {11'h0, fwd_level});
    xfer(1'b1, MK, 32'h0);
    src_pat <= 7'h7F;
    for (int l = 0; l < 8; l++) begin
      lv = l[2:0];
      xfer(1'b1, P1, {5'h1F, lv, 5'h1F, lv, 5'h1F, lv, 5'h1F, lv});
      xfer(1'b1, P2, {5'h1F, lv, 13'h1FFF, lv, 5'h1F, lv});
      rchk("prio1", P1, {5'h0, lv, 5'h0, lv, 5'h0, lv, 5'h0, lv});
      rchk("prio2", P2, {5'h0, lv, 13'h0, lv, 5'h0, lv});
      repeat (3) @(posedge hclk);
      chk("fwd_req", {25'h0, {7{lv != 3'h0}}}, {25'h0, fwd_req});
      chk("best", {29'h0, lv}, {29'h0, best_lvl});
    end
    xfer(1'b1, P1, 32'h0102_0304);
    xfer(1'b1, P2, 32'h0500_0607);
    for (int i = 0; i < 7; i++) begin
      src_pat <= 7'h01 << i;
      repeat (4) @(posedge hclk);
      chk("lvl", i + 1, 32'(best_lvl));
    end
    chk("irq_masked", 32'h0, {31'h0, irq});
    rchk("status", ST, 32'h7F);
    xfer(1'b1, ST, 32'h7F);
    rchk("status_clr", ST, 32'h0);
    xfer(1'b1, MK, 32'h01);
    src_pat <= 7'h00;
    repeat (3) @(posedge hclk);
    src_pat <= 7'h01;
    repeat (4) @(posedge hclk);
    chk("irq", 32'h1, {31'h0, irq});
    rchk("src_state", ispr_pkg::ADDR_SRC_STATE, 32'h01);
    xfer(1'b1, ST, 32'h01);
    @(posedge hclk);
    chk("irq_clr", 32'h0, {31'h0, irq});
    xfer(1'b1, 16'hF700, 32'hFFFF_FFFF);
    rchk("unmapped", 16'hF700, 32'h0);
    // second reset in mid-run with fields programmed nonzero
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk("prio1_rst", P1, 32'h0);
    rchk("prio2_rst", P2, 32'h0);
    chk("fwd_rst", 32'h0, {11'h0, fwd_level});
    print_verdict;
  end
endmodule
